// file: tb/malc_audio_src.sv
`timescale 1ns/10ps
module malc_audio_src
(
    // clock and level select
    input logic clk_sys,
    input logic loud,
    // audio toward the codec
    output logic frame_clock,
    output logic [15:0] leftSample,
    output logic [15:0] rightSample
);
    // ----------------------------------------
    // frame generator
    // ----------------------------------------
    // eight clocks a frame keeps the sample counts short
    logic [2:0] tick = 3'h0;
    logic flip = 1'b0;
    logic [15:0] mag;
    assign mag = loud ? 16'h7000 : 16'h0100;
    initial
    begin
        frame_clock = 1'b0;
        leftSample = 16'h0000;
        rightSample = 16'h0000;
    end
    always @(posedge clk_sys)
    begin
        tick <= tick + 3'h1;
        frame_clock <= #1 (tick == 3'h7 || tick < 3'h3);
        if (tick == 3'h7)
        begin
            // sign flips each frame so zero crossings keep coming
            flip <= ~flip;
            leftSample <= #1 flip ? mag : -mag;
            rightSample <= #1 flip ? -mag : mag;
        end
    end
endmodule // malc_audio_src

// file: tb/malc_level_ctrl_assertions.sv
`timescale 1ns/10ps
module malc_level_ctrl_chk
(
    // clock and reset
    input logic clk_sys,
    input logic reset_n,
    input logic power_down_n,
    // control port
    input logic regWrite,
    input logic regRead,
    input logic [7:0] regAddr,
    input logic [7:0] regWdata,
    input logic [7:0] regRdata,
    // gain and attenuation
    input logic [6:0] leftGainCode,
    input logic [6:0] rightGainCode,
    input logic [7:0] left_atten_code,
    input logic [7:0] right_atten_code,
    input logic [2:0] mic_stereo_mix_atten,
    input logic mic_mono_mix_atten,
    input logic [3:0] aux_volume,
    input logic spk_level_ctrl_en
);
    // ----------------------------------------
    // settle tracking
    // ----------------------------------------
    // writes are dropped while the soft reset lingers, so wait it out
    logic [2:0] upCount;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            upCount <= 3'h0;
        else if (!power_down_n)
            upCount <= 3'h0;
        else if (upCount != 3'h7)
            upCount <= upCount + 3'h1;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_rdata_hold: assert property (upCount == 3'h7 && !regRead |=> $stable(regRdata))
        else $error("read data moved without a read");
    a_gain_range: assert property (leftGainCode <= 7'h47 && rightGainCode <= 7'h47)
        else $error("gain code above top code");
    a_spk_reset: assert property ($rose(reset_n) |-> spk_level_ctrl_en)
        else $error("speaker level control off after reset");
    a_atten_reset: assert property ($rose(reset_n) |->
        {left_atten_code, right_atten_code} == 16'h0000)
        else $error("output attenuation not cleared by reset");
    a_mix_reset: assert property ($rose(reset_n) |->
        {mic_mono_mix_atten, mic_stereo_mix_atten, aux_volume} == 8'h57)
        else $error("mixer attenuation default wrong");
    a_gain_reset: assert property ($rose(reset_n) |->
        leftGainCode == 7'h10 && rightGainCode == 7'h10)
        else $error("gain default wrong after reset");
    a_atten_write: assert property (upCount == 3'h7 && regWrite && regAddr == 8'h0c |=>
        left_atten_code == $past(regWdata))
        else $error("left attenuation write lost");
    a_mix_write: assert property (upCount == 3'h7 && regWrite && regAddr == 8'h0e |=>
        {mic_mono_mix_atten, mic_stereo_mix_atten, aux_volume} == $past(regWdata))
        else $error("mixer attenuation write lost");
endmodule // malc_level_ctrl_chk

bind malc_level_ctrl malc_level_ctrl_chk malc_level_ctrl_chk_inst
(
    .clk_sys, .reset_n, .power_down_n, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
    .leftGainCode, .rightGainCode, .left_atten_code, .right_atten_code,
    .mic_stereo_mix_atten, .mic_mono_mix_atten, .aux_volume, .spk_level_ctrl_en
);

// file: tb/malc_level_ctrl_tb.sv
`timescale 1ns/10ps
module malc_level_ctrl_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_sys, reset_n, power_down_n, regWrite, regRead, loud, frame_clock;
    logic [7:0] regAddr, regWdata, regRdata, left_atten_code, right_atten_code;
    logic [15:0] leftSample, rightSample, dacSample;
    logic [6:0] leftGainCode, rightGainCode;
    logic [2:0] mic_stereo_mix_atten;
    logic [3:0] aux_volume;
    logic mic_mono_mix_atten, spk_level_ctrl_en, dacNegative;
    logic [14:0] dacMagnitude;
    integer failCount, totalChecks, cycleCount, i;
    malc_level_ctrl malc_level_ctrl_inst
    (
        .clk_sys, .reset_n, .power_down_n, .regWrite, .regRead, .regAddr, .regWdata,
        .regRdata, .frame_clock, .leftSample, .rightSample, .dacSample, .leftGainCode,
        .rightGainCode, .left_atten_code, .right_atten_code, .mic_stereo_mix_atten,
        .mic_mono_mix_atten, .aux_volume, .spk_level_ctrl_en, .dacNegative, .dacMagnitude
    );
    malc_audio_src malc_audio_src_inst (.clk_sys, .loud, .frame_clock, .leftSample, .rightSample);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task closeOut;
    begin
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task chk(input [15:0] seen, input [15:0] exp);
    begin
        totalChecks = totalChecks + 1;
        if (seen !== exp)
        begin
            failCount = failCount + 1;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task cyc(input integer n);
    begin
        repeat (n) @(posedge clk_sys);
        #1;
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        cyc(1);
        regWrite = 1'b0;
        // one idle edge so back to back writes never retoggle the strobe at once
        cyc(1);
    end
    endtask
    task rd(input [7:0] a, input [7:0] e);
    begin
        regAddr = a;
        regRead = 1'b1;
        cyc(1);
        regRead = 1'b0;
        cyc(1);
        chk(regRdata, e);
    end
    endtask
    // both channels must leave the old code before the new one is judged
    task waitg(input [6:0] prev, input [6:0] e, input integer n);
        integer k;
    begin
        k = 0;
        while ((leftGainCode === prev || rightGainCode === prev) && k < n)
        begin
            cyc(1);
            k = k + 1;
        end
        chk({leftGainCode, rightGainCode}, {e, e});
    end
    endtask
    task pdnPulse;
    begin
        power_down_n = 1'b0;
        cyc(34);
        power_down_n = 1'b1;
        cyc(8);
    end
    endtask
    // ----------------------------------------
    // clock, timeout, sequence
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycleCount = cycleCount + 1;
        if (cycleCount == 40000)
        begin
            failCount = failCount + 1;
            closeOut;
        end
    end
    initial
    begin
        {reset_n, regWrite, regRead, loud} = 4'h0;
        power_down_n = 1'b0;
        {regAddr, regWdata} = 16'h0000;
        dacSample = 16'h0000;
        {failCount, totalChecks, cycleCount} = 0;
        cyc(2);
        reset_n = 1'b1;
        pdnPulse;
        rd(8'h00, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h40);
        rd(8'h0a, 8'h36);
        rd(8'h0b, 8'h10);
        rd(8'h0d, 8'h00);
        rd(8'h0e, 8'h57);
        rd(8'h3f, 8'h00);
        chk(spk_level_ctrl_en, 1);
        wr(8'h0c, 8'ha5);
        wr(8'h0d, 8'h5a);
        wr(8'h0e, 8'hf3);
        chk({left_atten_code, right_atten_code}, 16'ha55a);
        chk({mic_mono_mix_atten, mic_stereo_mix_atten, aux_volume}, 16'h00f3);
        rd(8'h0d, 8'h5a);
        wr(8'h0a, 8'hff);
        rd(8'h0a, 8'h7f);
        wr(8'h0a, 8'h15);
        wr(8'h00, 8'h01);
        // speaker route bits live outside this block; the write must be ignored
        wr(8'h02, 8'h03);
        rd(8'h02, 8'h00);
        wr(8'h00, 8'h03);
        wr(8'h0b, 8'h12);
        waitg(7'h10, 7'h12, 2000);
        wr(8'h09, 8'h72);
        waitg(7'h12, 7'h14, 1300);
        waitg(7'h14, 7'h15, 1300);
        cyc(1500);
        chk({leftGainCode, rightGainCode}, {7'h15, 7'h15});
        wr(8'h09, 8'h7e);
        loud = 1'b1;
        cyc(8);
        loud = 1'b0;
        waitg(7'h15, 7'h11, 100);
        rd(8'h0b, 8'h12);
        loud = 1'b1;
        for (i = 0; i < 4; i = i + 1)
            waitg(7'h11 - 4 * i, 7'h0d - 4 * i, 100);
        waitg(7'h01, 7'h00, 100);
        cyc(100);
        chk({leftGainCode, rightGainCode}, 16'h0000);
        loud = 1'b0;
        wr(8'h09, 8'h5e);
        cyc(2000);
        chk({leftGainCode, rightGainCode}, 16'h0000);
        // longer wait select and single step: no rise after 128 samples
        wr(8'h08, 8'h04);
        wr(8'h09, 8'h70);
        cyc(1900);
        chk({leftGainCode, rightGainCode}, 16'h0000);
        waitg(7'h00, 7'h01, 300);
        wr(8'h00, 8'h01);
        waitg(7'h01, 7'h10, 100);
        dacSample = 16'h8000;
        cyc(20);
        chk({dacNegative, dacMagnitude}, 16'hffff);
        dacSample = 16'h7fff;
        cyc(20);
        chk({dacNegative, dacMagnitude}, 16'h7fff);
        wr(8'h0c, 8'h11);
        pdnPulse;
        rd(8'h0c, 8'h00);
        rd(8'h0a, 8'h36);
        closeOut;
    end
endmodule // malc_level_ctrl_tb

// file: verilog/malc_defines.vh
`ifndef MALC_DEFINES_VH
`define MALC_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define MALC_ADDR_MODE 8'h09
`define MALC_ADDR_REF 8'h0a
`define MALC_ADDR_GAIN 8'h0b
`define MALC_ADDR_ATTL 8'h0c
`define MALC_ADDR_ATTR 8'h0d
`define MALC_ADDR_VOL 8'h0e
`define MALC_ADDR_TIMER 8'h08
`define MALC_ADDR_PWR 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define MALC_MODE_THR 0
`define MALC_MODE_RSTEP 1
`define MALC_MODE_LSTEP_LO 2
`define MALC_MODE_ZCDIS 4
`define MALC_MODE_MICEN 5
`define MALC_MODE_SPKEN 6
`define MALC_TMR_WAIT_LO 2
`define MALC_TMR_ZTO_LO 4
`define MALC_PWR_VCM 0
`define MALC_PWR_MIC 1
// ----------------------------------------
// reset values
// ----------------------------------------
`define MALC_RST_MODE 8'h40
`define MALC_RST_REF 7'h36
`define MALC_RST_GAIN 7'h10
`define MALC_RST_ATT 8'h00
`define MALC_RST_VOL 8'h57
`define MALC_RST_TIMER 8'h00
`define MALC_RST_PWR 8'h00
`define MALC_GAIN_MIN 7'h00
`define MALC_GAIN_MAX 7'h47
// ----------------------------------------
// timing
// ----------------------------------------
`define MALC_PDN_MIN_NS 150
`define MALC_CLK_NS 5
`define MALC_PDN_MIN_CYC ((`MALC_PDN_MIN_NS + `MALC_CLK_NS - 1) / `MALC_CLK_NS)
`define MALC_BASE_FS 128
`define MALC_LEVEL_6DB 16'h4026
`define MALC_LEVEL_4DB 16'h50c2
`define MALC_LEVEL_8DB 16'h32f5
`define MALC_LEVEL_6DB_LOW 16'h4026
`endif

// file: verilog/malc_level_ctrl.v
// Operation
// [RQ1] recovery raises gain one step, or two with recovery step select set
// [RQ2] recovery never lifts gain above the recovery ceiling; clamps at ceiling
// [RQ3] limiter lowers gain by one to four steps per limiter step field
// [RQ4] limiter attenuation saturates at code zero, minus eight decibels
// [RQ5] zero cross enabled: each channel updates at its zero crossing or timeout
// [RQ6] zero cross disabled: gain changes apply immediately
// [RQ7] mic level control resets off, speaker level control resets on
// [RQ8] seven bit recovery ceiling resets to 36h
// [RQ9] gain codes step half a decibel, 00h is -8 dB, 10h is 0 dB
// [RQ10] host writes gain only with mic powered and mic level control off
// [RQ11] mic power off resets active gain to 10h, restarting from there
// [RQ12] disabling mic level control keeps last automatic gain
// [RQ13] gain register reads back last host write, not active gain
// [RQ14] left and right output attenuation registers reset to 00h
// [RQ15] mic to stereo mixer attenuation, 7h is -6 dB to 0h -27 dB
// [RQ16] mic to mono mixer attenuation bit, 0 gives 0 dB, 1 gives -4 dB
// [RQ17] dac samples are sixteen bit two's complement
// [RQ18] power down pin low at least 150 ns resets all registers to default
// [RQ19] host powers common voltage before any other block
// [RQ20] host supplies master, bit and frame clocks while functions run
// [RQ21] host sets mono to speaker and speaker route bits for speaker use
// [RQ22] limiter threshold -6 or -4 dBFS, wait reset band 2 dB lower
// [RQ23] recovery waits 128 to 1024 samples with no limiter events
// [RQ24] zero cross timeout 128 to 1024 samples
// [RQ25] decisions evaluated once per sample, strobe from frame clock
`timescale 1ns/10ps
`include "malc_defines.vh"
module malc_level_ctrl
(
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    input wire power_down_n,
    // control port
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    // audio side
    input wire frame_clock,
    input wire [15:0] leftSample,
    input wire [15:0] rightSample,
    input wire [15:0] dacSample,
    // gain and attenuation outputs
    output reg [6:0] leftGainCode,
    output reg [6:0] rightGainCode,
    output reg [7:0] left_atten_code,
    output reg [7:0] right_atten_code,
    output reg [2:0] mic_stereo_mix_atten,
    output reg mic_mono_mix_atten,
    output reg [3:0] aux_volume,
    output reg spk_level_ctrl_en,
    output reg dacNegative,
    output reg [14:0] dacMagnitude
);
// ----------------------------------------
// reset: async pin or register reset via power down
// ----------------------------------------
wire pdnSync;
wire frameSync;
malc_sync uPdnSync
(
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .asyncIn(power_down_n),
    .syncOut(pdnSync)
);
malc_sync uFrameSync
(
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .asyncIn(frame_clock),
    .syncOut(frameSync)
);
// pdn low shorter than minimum is ignored to reject glitches
// set edge is the last low sample, so a pulse of exactly the minimum still resets
localparam [31:0] PDN_MIN_CYC = `MALC_PDN_MIN_CYC;
reg [7:0] pdnCnt_reg;
reg softReset_reg;
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
    begin
        pdnCnt_reg <= 8'h00;
        softReset_reg <= 1'b1;
    end
    else if (!pdnSync)
    begin
        if (pdnCnt_reg < PDN_MIN_CYC[7:0] - 8'h01)
            pdnCnt_reg <= pdnCnt_reg + 8'h01;
        else
            softReset_reg <= 1'b1; // RQ18
    end
    else
    begin
        pdnCnt_reg <= 8'h00;
        softReset_reg <= 1'b0; // RQ18
    end
end
// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] mode_reg;
reg [6:0] ceiling_reg;
reg [6:0] hostGain_reg;
reg [7:0] timer_reg;
reg [7:0] pwr_reg;
wire recovery_step_sel = mode_reg[`MALC_MODE_RSTEP];
wire [1:0] limiter_step_sel = mode_reg[`MALC_MODE_LSTEP_LO+1:`MALC_MODE_LSTEP_LO];
wire zero_cross_disable = mode_reg[`MALC_MODE_ZCDIS];
wire mic_level_ctrl_en = mode_reg[`MALC_MODE_MICEN];
wire limiter_threshold_sel = mode_reg[`MALC_MODE_THR];
wire [1:0] recovery_wait_sel = timer_reg[`MALC_TMR_WAIT_LO+1:`MALC_TMR_WAIT_LO];
wire [1:0] zero_cross_timeout_sel = timer_reg[`MALC_TMR_ZTO_LO+1:`MALC_TMR_ZTO_LO];
wire mic_block_power = pwr_reg[`MALC_PWR_MIC];
wire hostGainWr = regWrite && (regAddr == `MALC_ADDR_GAIN);
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
    begin
        mode_reg <= `MALC_RST_MODE; // RQ7
        ceiling_reg <= `MALC_RST_REF; // RQ8
        hostGain_reg <= `MALC_RST_GAIN;
        timer_reg <= `MALC_RST_TIMER;
        pwr_reg <= `MALC_RST_PWR;
        left_atten_code <= `MALC_RST_ATT; // RQ14
        right_atten_code <= `MALC_RST_ATT; // RQ14
        {mic_mono_mix_atten, mic_stereo_mix_atten, aux_volume} <= `MALC_RST_VOL;
    end
    else if (softReset_reg)
    begin
        mode_reg <= `MALC_RST_MODE; // RQ18
        ceiling_reg <= `MALC_RST_REF;
        hostGain_reg <= `MALC_RST_GAIN;
        timer_reg <= `MALC_RST_TIMER;
        pwr_reg <= `MALC_RST_PWR;
        left_atten_code <= `MALC_RST_ATT;
        right_atten_code <= `MALC_RST_ATT;
        {mic_mono_mix_atten, mic_stereo_mix_atten, aux_volume} <= `MALC_RST_VOL;
    end
    else if (regWrite)
    begin
        case (regAddr)
            `MALC_ADDR_PWR: pwr_reg <= regWdata;
            `MALC_ADDR_TIMER: timer_reg <= {1'b0, regWdata[6:0]};
            `MALC_ADDR_MODE: mode_reg <= {1'b0, regWdata[6:0]};
            `MALC_ADDR_REF: ceiling_reg <= regWdata[6:0];
            `MALC_ADDR_GAIN: hostGain_reg <= regWdata[6:0];
            `MALC_ADDR_ATTL: left_atten_code <= regWdata;
            `MALC_ADDR_ATTR: right_atten_code <= regWdata;
            // RQ15 RQ16
            `MALC_ADDR_VOL: {mic_mono_mix_atten, mic_stereo_mix_atten, aux_volume} <= regWdata;
            default: ;
        endcase
    end
end
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
        spk_level_ctrl_en <= 1'b1;
    else
        spk_level_ctrl_en <= mode_reg[`MALC_MODE_SPKEN]; // RQ7
end
// ----------------------------------------
// read back: gain reads host value, not active gain
// ----------------------------------------
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
        regRdata <= 8'h00;
    else if (regRead)
    begin
        case (regAddr)
            `MALC_ADDR_PWR: regRdata <= pwr_reg;
            `MALC_ADDR_TIMER: regRdata <= timer_reg;
            `MALC_ADDR_MODE: regRdata <= mode_reg;
            `MALC_ADDR_REF: regRdata <= {1'b0, ceiling_reg};
            `MALC_ADDR_GAIN: regRdata <= {1'b0, hostGain_reg}; // RQ13
            `MALC_ADDR_ATTL: regRdata <= left_atten_code;
            `MALC_ADDR_ATTR: regRdata <= right_atten_code;
            `MALC_ADDR_VOL: regRdata <= {mic_mono_mix_atten, mic_stereo_mix_atten, aux_volume};
            default: regRdata <= 8'h00;
        endcase
    end
end
// ----------------------------------------
// sample strobe from frame clock rising edge
// ----------------------------------------
reg frameDly_reg;
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
        frameDly_reg <= 1'b0;
    else
        frameDly_reg <= frameSync;
end
wire sampleStrobe = frameSync && !frameDly_reg; // RQ25
// ----------------------------------------
// level detection
// ----------------------------------------
wire [15:0] leftAbs = leftSample[15] ? (~leftSample) : leftSample;
wire [15:0] rightAbs = rightSample[15] ? (~rightSample) : rightSample;
wire [15:0] limThr = limiter_threshold_sel ? `MALC_LEVEL_4DB : `MALC_LEVEL_6DB; // RQ22
wire [15:0] waitThr = limiter_threshold_sel ? `MALC_LEVEL_6DB_LOW : `MALC_LEVEL_8DB; // RQ22
wire overLimit = (leftAbs >= limThr) || (rightAbs >= limThr); // RQ3
wire inWaitBand = (leftAbs >= waitThr) || (rightAbs >= waitThr);
// ----------------------------------------
// recovery wait and zero cross timeout counters
// ----------------------------------------
reg [10:0] waitCnt_reg;
reg [10:0] ztoCnt_reg;
localparam [31:0] BASE_FS = `MALC_BASE_FS;
wire [10:0] waitLimit = BASE_FS[10:0] << recovery_wait_sel; // RQ23
wire [10:0] ztoLimit = BASE_FS[10:0] << zero_cross_timeout_sel; // RQ24
wire alcActive = mic_level_ctrl_en && mic_block_power;
wire recoverDue = alcActive && sampleStrobe && !overLimit && !inWaitBand
    && (waitCnt_reg >= waitLimit - 11'd1);
wire limitDue = alcActive && sampleStrobe && overLimit;
wire ztoExpire = sampleStrobe && (ztoCnt_reg >= ztoLimit - 11'd1);
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
    begin
        waitCnt_reg <= 11'd0;
        ztoCnt_reg <= 11'd0;
    end
    else if (sampleStrobe)
    begin
        if (!alcActive || overLimit || inWaitBand || recoverDue)
            waitCnt_reg <= 11'd0; // RQ23
        else
            waitCnt_reg <= waitCnt_reg + 11'd1;
        if (ztoExpire)
            ztoCnt_reg <= 11'd0;
        else
            ztoCnt_reg <= ztoCnt_reg + 11'd1;
    end
end
// ----------------------------------------
// target gain
// ----------------------------------------
reg [6:0] target_reg;
reg [6:0] target_next;
reg [2:0] limSteps;
reg [7:0] upSum;
always @*
begin
    target_next = target_reg;
    limSteps = {1'b0, limiter_step_sel} + 3'd1; // RQ3
    upSum = {1'b0, target_reg} + (recovery_step_sel ? 8'd2 : 8'd1); // RQ1 RQ9
    if (limitDue)
    begin
        if (target_reg < {4'd0, limSteps})
            target_next = `MALC_GAIN_MIN; // RQ4
        else
            target_next = target_reg - {4'd0, limSteps}; // RQ3
    end
    else if (recoverDue && target_reg < ceiling_reg)
    begin
        if (upSum > {1'b0, ceiling_reg})
            target_next = ceiling_reg; // RQ2
        else
            target_next = upSum[6:0]; // RQ1
    end
end
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
        target_reg <= `MALC_RST_GAIN;
    else if (softReset_reg || !mic_block_power)
        target_reg <= `MALC_RST_GAIN; // RQ11
    else if (hostGainWr && !mic_level_ctrl_en)
        target_reg <= regWdata[6:0]; // RQ10
    else
        target_reg <= target_next; // RQ12
end
// ----------------------------------------
// per channel application at zero cross
// ----------------------------------------
reg leftSign_reg;
reg rightSign_reg;
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
    begin
        leftSign_reg <= 1'b0;
        rightSign_reg <= 1'b0;
    end
    else if (sampleStrobe)
    begin
        leftSign_reg <= leftSample[15];
        rightSign_reg <= rightSample[15];
    end
end
wire leftZc = sampleStrobe && (leftSample[15] != leftSign_reg);
wire rightZc = sampleStrobe && (rightSample[15] != rightSign_reg);
wire leftApply = zero_cross_disable || leftZc || ztoExpire; // RQ5 RQ6
wire rightApply = zero_cross_disable || rightZc || ztoExpire; // RQ5 RQ6
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
    begin
        leftGainCode <= `MALC_RST_GAIN;
        rightGainCode <= `MALC_RST_GAIN;
    end
    else if (softReset_reg || !mic_block_power)
    begin
        leftGainCode <= `MALC_RST_GAIN; // RQ11
        rightGainCode <= `MALC_RST_GAIN;
    end
    else
    begin
        if (leftApply)
            leftGainCode <= target_reg; // RQ5
        if (rightApply)
            rightGainCode <= target_reg; // RQ5
    end
end
// ----------------------------------------
// dac sample decode, two's complement
// ----------------------------------------
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
    begin
        dacNegative <= 1'b0;
        dacMagnitude <= 15'h0000;
    end
    else if (sampleStrobe)
    begin
        dacNegative <= dacSample[15]; // RQ17
        dacMagnitude <= dacSample[15] ? (~dacSample[14:0]) : dacSample[14:0]; // RQ17
    end
end
endmodule // malc_level_ctrl

// file: verilog/malc_sync.v
`timescale 1ns/10ps
module malc_sync
(
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    // async in, synced out
    input wire asyncIn,
    output wire syncOut
);
reg stage1_reg;
reg stage2_reg;
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
    begin
        stage1_reg <= 1'b0;
        stage2_reg <= 1'b0;
    end
    else
    begin
        stage1_reg <= asyncIn;
        stage2_reg <= stage1_reg;
    end
end
assign syncOut = stage2_reg;
endmodule // malc_sync
